// >>> src/lvd_pkg.sv
// Purpose: Shared constants for the supply low-voltage detect controller
// Assumes: Classic Wishbone register access, 32-bit data, byte addresses
// Notes: Register offsets are byte addresses of aligned words
package lvd_pkg;
    // Register map
    localparam logic [3:0] LVD_CTRL_OFS = 4'h0;
    localparam logic [3:0] LVD_STAT_OFS = 4'h4;
    localparam logic [3:0] LVD_MASK_OFS = 4'h8;
    localparam logic [3:0] LVD_TAP_OFS = 4'hc;
    // Control register fields
    localparam int LVD_TRIP_LSB = 0;
    localparam int LVD_TRIP_W = 4;
    localparam int LVD_EN_BIT = 4;
    localparam int LVD_STABLE_BIT = 5;
    localparam logic [3:0] LVD_TRIP_RESET = 4'h5;
    localparam logic [3:0] LVD_TRIP_EXT = 4'hf;
    localparam logic [3:0] LVD_TRIP_RSVD = 4'h0;
    // Status and mask bits
    localparam int LVD_EV_TRIP = 0;
    localparam int LVD_EV_STABLE = 1;
    localparam int LVD_EV_W = 2;
    // Reference settle time
    localparam int LVD_CLK_HZ = 25000000;
    localparam int LVD_SETTLE_US = 50;
    localparam int LVD_SETTLE_CYC = (LVD_SETTLE_US * (LVD_CLK_HZ / 1000000));
endpackage : lvd_pkg

// >>> src/lvd_settle.sv
// Purpose: Counts reference settle time after the detector powers up
// Assumes: Enable is a synchronous level
// Notes: Counter restarts whenever the enable drops
`timescale 1ns/1ns
module lvd_settle
    import lvd_pkg::*;
#(
    parameter int SETTLE_CYC = LVD_SETTLE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    output logic stable_o
);
    localparam int CW = $clog2(SETTLE_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(SETTLE_CYC - 1);
    logic [CW-1:0] count_reg;
    logic stable_reg;
    wire done = (count_reg == LAST);

    // Stable only after a full settle period with power held on
    always_ff @(posedge clk_i) begin
        if (rst_i || !enable_i) begin
            count_reg <= '0;
            stable_reg <= 1'b0;
        end else if (!stable_reg) begin
            count_reg <= count_reg + CW'(1);
            stable_reg <= done;
        end
    end
    assign stable_o = stable_reg;
endmodule : lvd_settle

// >>> src/lvd_ctrl.sv
// Purpose: Control, flag and interrupt logic of a supply low-voltage detector
// Assumes: Analog comparator result arrives synchronous, high when tap <= reference
// Notes: Event flags clear on a status read; the set wins over the clear
`timescale 1ns/1ns

// Overview of operation
// (RULE1) Supply below trip point sets event flag
// (RULE2) Enabled event raises the interrupt request
// (RULE3) Tap compared to 1.2V, equality trips
// (RULE4) Four-bit trip code in control bits 3:0
// (RULE5) Code 1111 selects external analog input
// (RULE6) Codes 1..14 are fixed taps; 0 reserved
// (RULE7) Bit 4 powers the detector up
// (RULE8) Bit 5 is read-only reference stable flag
// (RULE9) Software keeps interrupt off until stable
// (RULE10) Bits 7:6 always read zero
// (RULE11) Reset: stable 0, enable 0, code 0101
// (RULE12) Software follows the documented setup order
// (RULE13) No event flag before reference is stable
// (RULE14) Detector runs in sleep and wakes device
// (RULE15) Reset turns the detector off
// (RULE16) Event flag sticky until software clears it
module lvd_ctrl
    import lvd_pkg::*;
#(
    parameter int SETTLE_CYC = LVD_SETTLE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    input wire logic cmp_below_i,
    input wire logic sleep_i,
    output logic lowv_power_enable_o,
    output logic ext_input_sel_o,
    output logic [3:0] tap_sel_o,
    output logic irq_o,
    output logic wake_o
);
    logic [3:0] trip_select_code_reg;
    logic lowv_power_enable_reg;
    logic [LVD_EV_W-1:0] status_reg;
    logic [LVD_EV_W-1:0] status_next;
    logic [LVD_EV_W-1:0] mask_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic stable_prev_reg;
    logic ref_stable_flag;

    // Reference settle timer
    lvd_settle #(
        .SETTLE_CYC(SETTLE_CYC)
    ) u_settle (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(lowv_power_enable_reg),
        .stable_o(ref_stable_flag)
    );

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Bus decode; one-cycle ack, err for unmapped offsets
    wire req = cyc_i && stb_i && !ack_reg;
    wire ctrl_hit = hit(adr_i, LVD_CTRL_OFS);
    wire stat_hit = hit(adr_i, LVD_STAT_OFS);
    wire mask_hit = hit(adr_i, LVD_MASK_OFS);
    wire tap_hit = hit(adr_i, LVD_TAP_OFS);
    wire mapped = ctrl_hit || stat_hit || mask_hit || tap_hit;
    wire wr_ok = req && we_i && mapped && sel_i[0];
    wire ctrl_wr = wr_ok && ctrl_hit;
    wire mask_wr = wr_ok && mask_hit;
    wire stat_rd = req && !we_i && stat_hit;

    // Control readback; top bits are unimplemented zeros
    wire [7:0] ctrl_view = {2'b00, ref_stable_flag, lowv_power_enable_reg,
        trip_select_code_reg}; // RULE8 RULE10
    wire [31:0] rd_word = ctrl_hit ? {24'h000000, ctrl_view} :
        stat_hit ? {30'h0, status_reg} :
        mask_hit ? {30'h0, mask_reg} :
        tap_hit ? {28'h0, tap_sel_o} : 32'h00000000;

    // Detection valid only powered, settled and on a usable code
    wire code_ok = (trip_select_code_reg != LVD_TRIP_RSVD); // RULE6
    wire trip_ev = lowv_power_enable_reg && ref_stable_flag && code_ok
        && cmp_below_i; // RULE1 RULE3 RULE7 RULE13 RULE14
    wire stable_ev = ref_stable_flag && !stable_prev_reg;

    // Sticky events; a set in the read cycle survives the clear
    always_comb begin
        status_next = status_reg;
        if (stat_rd) begin
            status_next = '0;
        end
        if (trip_ev) begin
            status_next[LVD_EV_TRIP] = 1'b1; // RULE16
        end
        if (stable_ev) begin
            status_next[LVD_EV_STABLE] = 1'b1;
        end
    end

    // Control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trip_select_code_reg <= LVD_TRIP_RESET; // RULE11 RULE15
            lowv_power_enable_reg <= 1'b0; // RULE11 RULE15
        end else if (ctrl_wr) begin
            trip_select_code_reg <= dat_i[LVD_TRIP_LSB +: LVD_TRIP_W]; // RULE4
            lowv_power_enable_reg <= dat_i[LVD_EN_BIT]; // RULE7
        end
    end

    // Status, mask and edge tracking
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= '0;
            mask_reg <= '0;
            stable_prev_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            stable_prev_reg <= ref_stable_flag;
            if (mask_wr) begin
                mask_reg <= dat_i[LVD_EV_W-1:0];
            end
        end
    end

    // Bus answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= '0;
        end else begin
            ack_reg <= req && mapped;
            dat_reg <= (req && !we_i) ? rd_word : dat_reg;
        end
    end

    logic err_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_reg <= 1'b0;
        end else begin
            err_reg <= cyc_i && stb_i && !err_reg && !mapped;
        end
    end

    assign ack_o = ack_reg;
    assign err_o = err_reg;
    assign dat_o = dat_reg;
    // Analog steering: external pin when code is all ones
    assign ext_input_sel_o = (trip_select_code_reg == LVD_TRIP_EXT); // RULE5
    assign tap_sel_o = trip_select_code_reg; // RULE6
    assign lowv_power_enable_o = lowv_power_enable_reg; // RULE7
    // Level interrupt; CPU vectors on it and leaves sleep
    assign irq_o = |(status_reg & mask_reg); // RULE2
    assign wake_o = irq_o && sleep_i; // RULE14

    // Checks
    a_reset_state: assert property (@(posedge clk_i)
        rst_i |=> trip_select_code_reg == LVD_TRIP_RESET && !lowv_power_enable_reg) // RULE11
        else $error("reset state wrong");
    a_top_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && $past(req && !we_i && ctrl_hit) |-> dat_o[31:6] == '0) // RULE10
        else $error("top bits nonzero");
    a_trip_sets: assert property (@(posedge clk_i) disable iff (rst_i)
        trip_ev |=> status_reg[LVD_EV_TRIP]) // RULE1
        else $error("trip not flagged");
    a_no_unstable: assert property (@(posedge clk_i) disable iff (rst_i)
        !ref_stable_flag && !status_reg[LVD_EV_TRIP] |=> !status_reg[LVD_EV_TRIP]) // RULE13
        else $error("flag before stable");
    a_sticky_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        status_reg[LVD_EV_TRIP] && !stat_rd |=> status_reg[LVD_EV_TRIP]) // RULE16
        else $error("flag lost");
    a_irq_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        status_reg[LVD_EV_TRIP] && mask_reg[LVD_EV_TRIP] |-> irq_o) // RULE2
        else $error("irq missing");
    a_ext_select: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_wr && dat_i[3:0] == 4'hf |=> ext_input_sel_o) // RULE5
        else $error("ext input not routed");
    a_power_write: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_wr |=> lowv_power_enable_o == $past(dat_i[LVD_EN_BIT])) // RULE7 RULE4
        else $error("enable write lost");
    a_off_no_stable: assert property (@(posedge clk_i) disable iff (rst_i)
        !lowv_power_enable_reg |=> !ref_stable_flag) // RULE8
        else $error("stable while off");
    a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held");

    // Bus handshake: every taken request is answered one cycle later
    a_ack_answers: assert property (@(posedge clk_i) disable iff (rst_i)
        cyc_i && stb_i && !ack_o && mapped |=> ack_o)
        else $error("mapped request not acked");
    a_err_answers: assert property (@(posedge clk_i) disable iff (rst_i)
        cyc_i && stb_i && !err_o && !mapped |=> err_o)
        else $error("unmapped request not refused");
    a_err_one: assert property (@(posedge clk_i) disable iff (rst_i)
        err_o |=> !err_o)
        else $error("err held");
    a_ack_excl: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |-> !err_o)
        else $error("ack and err together");
    a_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");

    // Read data must be the word that stood when the read was taken
    a_ctrl_read: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && $past(req && !we_i && ctrl_hit) |-> dat_o[7:0] == $past(ctrl_view)) // RULE8
        else $error("control readback wrong");
    a_stat_read: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && $past(stat_rd) |-> dat_o[LVD_EV_W-1:0] == $past(status_reg))
        else $error("status readback wrong");
    a_mask_read: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && $past(req && !we_i && mask_hit) |-> dat_o[LVD_EV_W-1:0] == $past(mask_reg))
        else $error("mask readback wrong");
    a_tap_read: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && $past(req && !we_i && tap_hit) |-> dat_o[3:0] == $past(tap_sel_o)) // RULE6
        else $error("tap readback wrong");
    a_high_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && $past(req && !we_i && !ctrl_hit) |-> dat_o[31:4] == '0)
        else $error("unused read bits nonzero");
    a_dat_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(req && !we_i) |=> $stable(dat_o))
        else $error("read data moved");

    // Register writes land only when addressed and enabled
    a_code_write: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_wr |=> trip_select_code_reg == $past(dat_i[3:0])) // RULE4
        else $error("trip code write lost");
    a_ctrl_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_wr |=> $stable(trip_select_code_reg) && $stable(lowv_power_enable_reg)) // RULE4
        else $error("control changed without write");
    a_sel_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        req && we_i && ctrl_hit && !sel_i[0] |=> $stable(trip_select_code_reg))
        else $error("disabled byte written");
    a_err_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
        cyc_i && stb_i && we_i && !mapped |=> $stable(mask_reg))
        else $error("refused write landed");
    a_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
        mask_wr |=> mask_reg == $past(dat_i[LVD_EV_W-1:0]))
        else $error("mask write lost");
    a_mask_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !mask_wr |=> $stable(mask_reg))
        else $error("mask changed without write");
    a_ext_other: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_wr && dat_i[3:0] != 4'hf |=> !ext_input_sel_o) // RULE5
        else $error("ext input on fixed tap");
    a_ext_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        tap_sel_o == LVD_TRIP_EXT |-> ext_input_sel_o) // RULE5
        else $error("ext steering lost");

    // Event flags: read clears, set wins, sources gated by power and settle
    a_read_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        stat_rd && !trip_ev && !stable_ev |=> status_reg == '0) // RULE16
        else $error("status not cleared by read");
    a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        stat_rd && trip_ev |=> status_reg[LVD_EV_TRIP]) // RULE16
        else $error("trip lost to read clear");
    a_stable_event: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(ref_stable_flag) |=> status_reg[LVD_EV_STABLE]) // RULE8
        else $error("stable event missed");
    a_off_no_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        !lowv_power_enable_reg && !status_reg[LVD_EV_TRIP] |=> !status_reg[LVD_EV_TRIP]) // RULE7
        else $error("flag while powered down");
    a_trip_stable: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(status_reg[LVD_EV_TRIP]) |-> $past(ref_stable_flag)) // RULE13
        else $error("trip before settle");
    a_trip_power: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(status_reg[LVD_EV_TRIP]) |-> $past(lowv_power_enable_reg)) // RULE7
        else $error("trip while unpowered");
    a_trip_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(status_reg[LVD_EV_TRIP]) |-> $past(cmp_below_i)) // RULE1 RULE3
        else $error("trip without comparator");
    a_stable_wait: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(lowv_power_enable_reg) |=> !ref_stable_flag) // RULE13
        else $error("stable without settle");
    a_stable_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        ref_stable_flag && lowv_power_enable_reg |=> ref_stable_flag) // RULE8
        else $error("stable dropped while on");

    // Interrupt and wake outputs
    a_irq_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (status_reg & mask_reg) == '0 |-> !irq_o) // RULE2
        else $error("irq without unmasked event");
    a_irq_status: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o |-> |status_reg) // RULE2
        else $error("irq with empty status");
    a_wake_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o && sleep_i |-> wake_o) // RULE14
        else $error("no wake from sleep");
    a_wake_irq: assert property (@(posedge clk_i) disable iff (rst_i)
        wake_o |-> irq_o && sleep_i) // RULE14
        else $error("spurious wake");

    // Main scenarios reached
    c_trip_irq: cover property (@(posedge clk_i) disable iff (rst_i) irq_o && trip_ev);
    c_ext_mode: cover property (@(posedge clk_i) disable iff (rst_i) ext_input_sel_o && trip_ev);
    c_wake: cover property (@(posedge clk_i) disable iff (rst_i) wake_o);
    c_clear_race: cover property (@(posedge clk_i) disable iff (rst_i) stat_rd && trip_ev);
endmodule : lvd_ctrl

// >>> tb/lvd_cmp_model.sv
// Purpose: Supply divider, external pin and comparator model
// Assumes: Millivolt levels come from the bench
// Notes: Output chatters while unpowered
`timescale 1ns/1ns
module lvd_cmp_model (
    input wire logic clk_i,
    input wire logic pwr_i,
    input wire logic ext_i,
    input wire logic [3:0] tap_i,
    input wire logic [15:0] supply_mv_i,
    input wire logic [15:0] ext_mv_i,
    output logic below_o
);
    int thr[16] = '{0, 2060, 2270, 2470, 2580, 2780, 2890, 3100, 3410, 3610, 3720, 3920, 4130,
        4330, 4640, 0};
    logic chatter = 1'b0;
    // Unpowered output means nothing, so it toggles
    always @(posedge clk_i) chatter <= ~chatter;
    // Tap at or under 1.2V trips
    assign below_o = !pwr_i ? chatter : ext_i ? (ext_mv_i <= 16'd1200) :
        (int'(supply_mv_i) <= thr[tap_i]);
endmodule : lvd_cmp_model

// >>> tb/supply_low_voltage_detect_ctrl_tb.sv
// Purpose: Self-checking bench of the low-voltage detect controller
// Assumes: Settle count shortened to 8 cycles
// Notes: Seeded xorshift places supply levels near each trip point
`timescale 1ns/1ns
module supply_low_voltage_detect_ctrl_tb;
    import lvd_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, sleep = 1'b0;
    logic [3:0] adr = 4'h0, tap;
    logic [31:0] dat = 32'h0, dat_o, rd, seed = 32'hcfdd;
    logic ack_o, err_o, ef, cmp, pwr, ext, irq_o, wake_o;
    logic [15:0] sup = 16'd5000, extv = 16'd3000, v;
    int mismatches = 0, cmp_count = 0, cyc_n = 0;
    int thr[16] = '{0, 2060, 2270, 2470, 2580, 2780, 2890, 3100, 3410, 3610, 3720, 3920, 4130,
        4330, 4640, 0};
    lvd_ctrl #(.SETTLE_CYC(8)) lvd_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .err_o(err_o), .cmp_below_i(cmp), .sleep_i(sleep), .lowv_power_enable_o(pwr),
        .ext_input_sel_o(ext), .tap_sel_o(tap), .irq_o(irq_o), .wake_o(wake_o));
    lvd_cmp_model lvd_cmp_model_i (.clk_i(clk_i), .pwr_i(pwr), .ext_i(ext), .tap_i(tap),
        .supply_mv_i(sup), .ext_mv_i(extv), .below_o(cmp));
    // 40 ns clock
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // Hang guard
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // Trip expected at or under the chosen point
    function automatic logic exp_trip(int c);
        return (c == 15) ? (extv <= 16'd1200) : (int'(sup) <= thr[c]);
    endfunction : exp_trip
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Classic cycle; waits on ack or err, bounded
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
        rd = dat_o;
        ef = err_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n == 20) mismatches++;
    endtask : wb
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, LVD_CTRL_OFS, 8'h0);
        chk(rd, 32'h5);
        chk({pwr, ext, tap}, 32'h5);
        wb(1'b0, 4'h2, 8'h0);
        chk(ef, 1'b1);
        $display("map test done");
        // Supply already low at enable; no flag before settling
        sup <= 16'd1000;
        wb(1'b1, LVD_CTRL_OFS, 8'hd5);
        wb(1'b0, LVD_STAT_OFS, 8'h0);
        chk(rd, 32'h0);
        wb(1'b0, LVD_CTRL_OFS, 8'h0);
        chk(rd & 32'hdf, 32'h15);
        repeat (12) @(posedge clk_i);
        wb(1'b0, LVD_CTRL_OFS, 8'h0);
        chk(rd, 32'h35);
        wb(1'b0, LVD_STAT_OFS, 8'h0);
        chk(rd, 32'h3);
        $display("enable test done");
        // Trip codes 1 to 15; code 7 sits exactly on its point
        for (int c = 1; c < 16; c++) begin
            v = 16'(thr[c] - 100 + int'(rnd() % 200));
            if (c == 7) v = 16'(thr[c]);
            sup <= v;
            extv <= 16'(1100 + rnd() % 200);
            wb(1'b1, LVD_CTRL_OFS, {4'h1, 4'(c)});
            wb(1'b0, LVD_STAT_OFS, 8'h0);
            repeat (3) @(posedge clk_i);
            wb(1'b0, LVD_STAT_OFS, 8'h0);
            chk(rd[0], exp_trip(c));
            chk({ext, tap}, {c == 15, 4'(c)});
        end
        $display("trip code test done");
        // Interrupt, wake from sleep, sticky flag
        sup <= 16'd1000;
        wb(1'b1, LVD_CTRL_OFS, 8'h15);
        wb(1'b1, LVD_MASK_OFS, 8'h1);
        sleep <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(irq_o, 1'b1);
        chk(wake_o, 1'b1);
        sup <= 16'd5000;
        sleep <= 1'b0;
        wb(1'b1, LVD_MASK_OFS, 8'h0);
        repeat (4) @(posedge clk_i);
        chk(irq_o, 1'b0);
        wb(1'b0, LVD_STAT_OFS, 8'h0);
        chk(rd[0], 1'b1);
        wb(1'b0, LVD_STAT_OFS, 8'h0);
        chk(rd[0], 1'b0);
        $display("irq test done");
        // Powered down while the comparator chatters
        wb(1'b1, LVD_CTRL_OFS, 8'h05);
        wb(1'b0, LVD_STAT_OFS, 8'h0);
        repeat (6) @(posedge clk_i);
        wb(1'b0, LVD_STAT_OFS, 8'h0);
        chk({pwr, rd[0]}, 2'b00);
        // Reset in mid-run
        wb(1'b1, LVD_CTRL_OFS, 8'h18);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({pwr, tap}, 32'h5);
        wb(1'b0, LVD_CTRL_OFS, 8'h0);
        chk(rd, 32'h5);
        $display("reset test done");
        report_and_stop();
    end
endmodule : supply_low_voltage_detect_ctrl_tb
